/* File: mmc_meas_config.sv */
// measurement configuration register with peak hold and peak alerts
`timescale 1ns/100ps
`include "mmc_regs.svh"
module mmc_meas_config
(
  input  wire logic                     sys_clk,
  input  wire logic                     srst,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [6:0]               reg_addr,
  input  wire logic [15:0]              reg_wdata,
  output logic [23:0]                   reg_rdata,
  input  wire logic                     sample_valid,
  input  wire mmc_pkg::mmc_sample_t     volt_a,
  input  wire mmc_pkg::mmc_sample_t     volt_b,
  input  wire mmc_pkg::mmc_sample_t     volt_c,
  input  wire mmc_pkg::mmc_sample_t     curr_a,
  input  wire mmc_pkg::mmc_sample_t     curr_b,
  input  wire mmc_pkg::mmc_sample_t     curr_c,
  input  wire logic                     half_cycle_tick,
  output mmc_pkg::mmc_phase_sel_t       line_freq_phase_select,
  output logic                          peak_window_done,
  output logic                          volt_alert,
  output logic                          curr_alert
);
  import mmc_pkg::*;

  logic [7:0]      measurement_config_r;
  logic [15:0]     half_cycle_count_r;
  logic [7:0]      voltage_peak_threshold_r;
  logic [7:0]      current_peak_threshold_r;
  logic [23:0]     voltage_peak_value_r;
  logic [23:0]     current_peak_value_r;
  logic [2:0]      volt_flag_r;
  logic [2:0]      curr_flag_r;
  logic [15:0]     hcyc_cnt_r;
  mmc_state_t      state_r;
  logic [23:0]     voltage_peak_value_run;
  logic [23:0]     current_peak_value_run;
  logic            win_end;
  logic            win_clear;
  mmc_phase_mask_t peak_hold_phase_select;
  mmc_phase_mask_t peak_alert_phase_select;

  function automatic logic over_thr(input logic [23:0] s, input logic [7:0] thr);
    logic [23:0] a;
    a = s[23] ? 24'(-s) : s;
    over_thr = a[23:16] > thr;
  endfunction

  assign line_freq_phase_select = measurement_config_r[`MMC_FREQ_MSB:`MMC_FREQ_LSB]; // RULE1
  assign peak_hold_phase_select = measurement_config_r[`MMC_PKH_MSB:`MMC_PKH_LSB]; // RULE2
  assign peak_alert_phase_select = measurement_config_r[`MMC_PKA_MSB:`MMC_PKA_LSB]; // RULE6

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      measurement_config_r <= `MMC_CFG_RESET; // RULE1
    else if (reg_wr && reg_addr == `MMC_ADDR_MEAS_CFG)
      measurement_config_r <= reg_wdata[7:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      half_cycle_count_r       <= `MMC_HCYC_RESET;
      voltage_peak_threshold_r <= `MMC_THR_RESET;
      current_peak_threshold_r <= `MMC_THR_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `MMC_ADDR_HCYC)
        half_cycle_count_r <= reg_wdata;
      if (reg_addr == `MMC_ADDR_VTHR)
        voltage_peak_threshold_r <= reg_wdata[7:0];
      if (reg_addr == `MMC_ADDR_ITHR)
        current_peak_threshold_r <= reg_wdata[7:0];
    end
  end

  // half-cycle window sequencer
  assign win_end = (state_r == MMC_ST_RUN) && half_cycle_tick
                   && (hcyc_cnt_r <= 16'h0001); // RULE4
  assign win_clear = (state_r == MMC_ST_IDLE) || win_end;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_r    <= MMC_ST_IDLE;
      hcyc_cnt_r <= 16'h0000;
    end
    else
    begin
      case (state_r)
        MMC_ST_IDLE:
        begin
          state_r    <= MMC_ST_RUN;
          hcyc_cnt_r <= half_cycle_count_r;
        end
        MMC_ST_RUN:
        begin
          if (win_end)
            hcyc_cnt_r <= half_cycle_count_r; // RULE4
          else if (half_cycle_tick)
            hcyc_cnt_r <= hcyc_cnt_r - 16'h0001;
        end
        default:
          state_r <= MMC_ST_IDLE;
      endcase
    end
  end

  // voltage and current peaks run separately, over the same enabled phases
  mmc_peak_track u_voltage_peak_value // RULE5
  (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .clear        (win_clear),
    .sample_valid (sample_valid),
    .enable       (peak_hold_phase_select),
    .sample_a     (volt_a),
    .sample_b     (volt_b),
    .sample_c     (volt_c),
    .peak         (voltage_peak_value_run)
  );

  mmc_peak_track u_current_peak_value // RULE5
  (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .clear        (win_clear),
    .sample_valid (sample_valid),
    .enable       (peak_hold_phase_select),
    .sample_a     (curr_a),
    .sample_b     (curr_b),
    .sample_c     (curr_c),
    .peak         (current_peak_value_run)
  );

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      voltage_peak_value_r <= 24'h000000;
      current_peak_value_r <= 24'h000000;
      peak_window_done     <= 1'b0;
    end
    else
    begin
      peak_window_done <= win_end;
      if (win_end)
      begin
        voltage_peak_value_r <= voltage_peak_value_run; // RULE4
        current_peak_value_r <= current_peak_value_run; // RULE4
      end
    end
  end

  // sticky alert flags; set wins over the read-clear
  logic [2:0] v_hit;
  logic [2:0] i_hit;
  logic       alert_rd;
  always_comb
  begin
    v_hit[0] = over_thr(volt_a, voltage_peak_threshold_r); // RULE8
    v_hit[1] = over_thr(volt_b, voltage_peak_threshold_r);
    v_hit[2] = over_thr(volt_c, voltage_peak_threshold_r);
    i_hit[0] = over_thr(curr_a, current_peak_threshold_r); // RULE8
    i_hit[1] = over_thr(curr_b, current_peak_threshold_r);
    i_hit[2] = over_thr(curr_c, current_peak_threshold_r);
  end
  assign alert_rd = reg_rd && reg_addr == `MMC_ADDR_ALERT;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      volt_flag_r <= 3'h0;
      curr_flag_r <= 3'h0;
    end
    else
    begin
      volt_flag_r <= (alert_rd ? 3'h0 : volt_flag_r)
                     | ({3{sample_valid}} & v_hit & peak_alert_phase_select); // RULE7 RULE9
      curr_flag_r <= (alert_rd ? 3'h0 : curr_flag_r)
                     | ({3{sample_valid}} & i_hit & peak_alert_phase_select); // RULE7 RULE9
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      volt_alert <= 1'b0;
      curr_alert <= 1'b0;
    end
    else
    begin
      volt_alert <= |volt_flag_r; // RULE9
      curr_alert <= |curr_flag_r;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      reg_rdata <= 24'h000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `MMC_ADDR_MEAS_CFG: reg_rdata <= {16'h0000, measurement_config_r};
        `MMC_ADDR_VOLTAGE_PEAK_VALUE:    reg_rdata <= voltage_peak_value_r;
        `MMC_ADDR_CURRENT_PEAK_VALUE:    reg_rdata <= current_peak_value_r;
        `MMC_ADDR_ALERT:    reg_rdata <= {18'h00000, curr_flag_r, volt_flag_r};
        `MMC_ADDR_HCYC:     reg_rdata <= {8'h00, half_cycle_count_r};
        `MMC_ADDR_VTHR:     reg_rdata <= {16'h0000, voltage_peak_threshold_r};
        `MMC_ADDR_ITHR:     reg_rdata <= {16'h0000, current_peak_threshold_r};
        default:            reg_rdata <= 24'h000000;
      endcase
    end
  end
endmodule

/* File: mmc_regs.svh */
// register offsets, field positions and reset values
// How it works
// RULE1 - bits 1:0 pick line-frequency phase, reset zero
// RULE2 - bits 4:2 enable peak capture, reset seven
// RULE3 - bit 3 enables phase B peak capture
// RULE4 - peaks load when half-cycle window ends
// RULE5 - voltage and current peaks tracked independently
// RULE6 - bits 7:5 enable peak alerts, reset seven
// RULE7 - all selected alert phases monitored together
// RULE8 - compare samples against voltage/current thresholds
// RULE9 - exceeding threshold sets readable sticky flag
`ifndef MMC_REGS_SVH
`define MMC_REGS_SVH
`define MMC_ADDR_MEAS_CFG   7'h14
`define MMC_ADDR_VOLTAGE_PEAK_VALUE      7'h16
`define MMC_ADDR_CURRENT_PEAK_VALUE      7'h17
`define MMC_ADDR_ALERT      7'h18
`define MMC_ADDR_HCYC       7'h19
`define MMC_ADDR_VTHR       7'h1A
`define MMC_ADDR_ITHR       7'h1B
`define MMC_FREQ_LSB        0
`define MMC_FREQ_MSB        1
`define MMC_PKH_LSB         2
`define MMC_PKH_MSB         4
`define MMC_PKA_LSB         5
`define MMC_PKA_MSB         7
`define MMC_CFG_RESET       8'hFC
`define MMC_HCYC_RESET      16'hFFFF
`define MMC_THR_RESET       8'hFF
`define MMC_FREQ_RESERVED   2'h3
`endif

/* File: mmc_pkg.sv */
// types shared by the measurement configuration block
package mmc_pkg;
  typedef logic [1:0] mmc_phase_sel_t;
  typedef logic [2:0] mmc_phase_mask_t;
  typedef logic [23:0] mmc_sample_t;
  typedef enum logic [1:0]
  {
    MMC_ST_IDLE = 2'b01,
    MMC_ST_RUN  = 2'b10
  } mmc_state_t;
endpackage

/* File: mmc_peak_track.sv */
// per-quantity peak tracker across the enabled phases
`timescale 1ns/100ps
`include "mmc_regs.svh"
module mmc_peak_track
(
  input  wire logic                     sys_clk,
  input  wire logic                     srst,
  input  wire logic                     clear,
  input  wire logic                     sample_valid,
  input  wire mmc_pkg::mmc_phase_mask_t enable,
  input  wire mmc_pkg::mmc_sample_t     sample_a,
  input  wire mmc_pkg::mmc_sample_t     sample_b,
  input  wire mmc_pkg::mmc_sample_t     sample_c,
  output logic [23:0]                   peak
);
  import mmc_pkg::*;

  function automatic logic [23:0] absval(input logic [23:0] v);
    absval = v[23] ? 24'(-v) : v;
  endfunction

  logic [23:0] best;
  always_comb
  begin
    best = clear ? 24'h000000 : peak;
    if (enable[0] && absval(sample_a) > best)
      best = absval(sample_a);
    if (enable[1] && absval(sample_b) > best) // RULE3
      best = absval(sample_b);
    if (enable[2] && absval(sample_c) > best)
      best = absval(sample_c);
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      peak <= 24'h000000;
    else if (sample_valid)
      peak <= best;
    else if (clear)
      peak <= 24'h000000;
  end
endmodule

/* File: mmc_meas_config_assertions.sv */
// port assertions for the measurement configuration block
`timescale 1ns/100ps
module mmc_meas_config_chk
(
  input wire logic                    sys_clk,
  input wire logic                    srst,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [6:0]              reg_addr,
  input wire logic [15:0]             reg_wdata,
  input wire logic [23:0]             reg_rdata,
  input wire logic                    sample_valid,
  input wire logic                    half_cycle_tick,
  input wire mmc_pkg::mmc_phase_sel_t line_freq_phase_select,
  input wire logic                    peak_window_done,
  input wire logic                    volt_alert,
  input wire logic                    curr_alert
);
  import mmc_pkg::*;
  logic [1:0] wd_low;
  assign wd_low = reg_wdata[1:0];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_cfg_write;
    reg_wr && reg_addr == 7'h14;
  endsequence
  sequence s_flag_read;
    reg_rd && reg_addr == 7'h18 && !sample_valid ##1 1'b1;
  endsequence
  a_freq_write: assert property (s_cfg_write |=>
    line_freq_phase_select == $past(wd_low)) else $error("phase select not written");
  a_freq_reset: assert property ($fell(srst) |->
    line_freq_phase_select == 2'h0) else $error("phase select not cleared");
  a_freq_hold: assert property (!(reg_wr && reg_addr == 7'h14) |=>
    $stable(line_freq_phase_select)) else $error("phase select moved");
  a_cfg_readback: assert property (reg_rd && !reg_wr && reg_addr == 7'h14 |=>
    reg_rdata[1:0] == line_freq_phase_select && reg_rdata[23:8] == 16'h0)
    else $error("config readback wrong");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_done_tick: assert property (peak_window_done |->
    $past(half_cycle_tick) || $past(half_cycle_tick, 2)) else $error("done without tick");
  a_alert_cause: assert property ($rose(volt_alert) || $rose(curr_alert) |->
    $past(sample_valid, 2)) else $error("alert without sample");
  a_alert_clear: assert property (s_flag_read |=>
    !volt_alert && !curr_alert) else $error("alert not cleared");
endmodule
bind mmc_meas_config mmc_meas_config_chk u_chk (.sys_clk, .srst, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .sample_valid, .half_cycle_tick,
  .line_freq_phase_select, .peak_window_done, .volt_alert, .curr_alert);

/* File: mmc_host_model.sv */
// host model driving the register port
`timescale 1ns/100ps
module mmc_host_model
(
  input  wire logic        sys_clk,
  output logic             reg_wr = 1'b0,
  output logic             reg_rd = 1'b0,
  output logic [6:0]       reg_addr = 7'h0,
  output logic [15:0]      reg_wdata = 16'h0,
  input  wire logic [23:0] reg_rdata
);
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1 reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [23:0] v);
    @(posedge sys_clk);
    #1 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1 reg_rd = 1'b0;
    reg_addr = ~a;
    v = reg_rdata;
  endtask
endmodule

/* File: mmc_meas_config_bench.sv */
// self-checking bench for the measurement configuration block
`timescale 1ns/100ps
module mmc_meas_config_bench;
  import mmc_pkg::*;
  logic           sys_clk = 1'b0;
  logic           srst = 1'b1;
  logic           sample_valid = 1'b0;
  logic           half_cycle_tick = 1'b0;
  logic           reg_wr, reg_rd, peak_window_done, volt_alert, curr_alert;
  logic [6:0]     reg_addr;
  logic [15:0]    reg_wdata;
  logic [23:0]    reg_rdata, rv, ev, ei;
  mmc_sample_t    vs [3] = '{24'h0, 24'h0, 24'h0};
  mmc_sample_t    cs [3] = '{24'h0, 24'h0, 24'h0};
  mmc_phase_sel_t line_freq_phase_select;
  mmc_phase_mask_t pm;
  int             err_count = 0, tests_run = 0, n, seed = 32'ha578;
  always #4 sys_clk = ~sys_clk;
  mmc_meas_config u_dut (.sys_clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .sample_valid, .volt_a(vs[0]), .volt_b(vs[1]), .volt_c(vs[2]),
    .curr_a(cs[0]), .curr_b(cs[1]), .curr_c(cs[2]), .half_cycle_tick,
    .line_freq_phase_select, .peak_window_done, .volt_alert, .curr_alert);
  mmc_host_model u_host (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [23:0] mag(input logic [23:0] s);
    return s[23] ? -s : s;
  endfunction
  function automatic logic [23:0] rnd();
    logic [31:0] r;
    r = $random(seed);
    return {r[22], r[22:0]};
  endfunction
  task automatic wait_done(input int lim);
    n = 0;
    while (peak_window_done !== 1'b1 && n < lim)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n >= lim)
    begin
      err_count++;
      results();
    end
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    #1 srst = 1'b0;
    check(24'(line_freq_phase_select), 24'h0);
    u_host.rd(7'h14, rv);
    check(rv, 24'hFC);
    for (int i = 0; i < 4; i++)
    begin
      ev = {16'h0, 8'($random(seed))};
      ev[1:0] = 2'(i);
      u_host.wr(7'h14, ev[15:0]);
      u_host.rd(7'h14, rv);
      check(rv, ev);
      check(24'(line_freq_phase_select), 24'(i));
    end
    u_host.rd(7'h7F, rv);
    check(rv, 24'h0);
    u_host.wr(7'h19, 16'h1);
    u_host.wr(7'h14, 16'h0C);
    half_cycle_tick = 1'b1;
    wait_done(70000);
    half_cycle_tick = 1'b0;
    for (int j = 0; j < 3; j++)
    begin
      pm = (j == 0) ? 3'h3 : ((j == 1) ? 3'h2 : 3'h4);
      u_host.wr(7'h14, {11'h000, pm, 2'h0});
      ev = 24'h0;
      ei = 24'h0;
      repeat (4)
      begin
        for (int k = 0; k < 3; k++)
        begin
          vs[k] = rnd();
          cs[k] = rnd();
          if (pm[k])
          begin
            ev = (mag(vs[k]) > ev) ? mag(vs[k]) : ev;
            ei = (mag(cs[k]) > ei) ? mag(cs[k]) : ei;
          end
        end
        sample_valid = 1'b1;
        @(posedge sys_clk);
        #1;
      end
      sample_valid = 1'b0;
      half_cycle_tick = 1'b1;
      @(posedge sys_clk);
      #1 half_cycle_tick = 1'b0;
      wait_done(4);
      u_host.rd(7'h16, rv);
      check(rv, ev);
      u_host.rd(7'h17, rv);
      check(rv, ei);
    end
    u_host.wr(7'h1A, 16'h10);
    u_host.wr(7'h1B, 16'h10);
    u_host.wr(7'h14, 16'hC2);
    u_host.rd(7'h18, rv);
    vs = '{24'h300000, 24'h200000, 24'h0};
    cs = '{24'h0, 24'h100000, -24'h300000};
    sample_valid = 1'b1;
    @(posedge sys_clk);
    #1 sample_valid = 1'b0;
    @(posedge sys_clk);
    #1 check({22'h0, volt_alert, curr_alert}, 24'h3);
    u_host.rd(7'h18, rv);
    check(rv, 24'h22);
    u_host.rd(7'h18, rv);
    check(rv, 24'h0);
    check({22'h0, volt_alert, curr_alert}, 24'h0);
    srst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 srst = 1'b0;
    check(24'(line_freq_phase_select), 24'h0);
    u_host.rd(7'h14, rv);
    check(rv, 24'hFC);
    u_host.rd(7'h19, rv);
    check(rv, 24'hFFFF);
    u_host.rd(7'h1A, rv);
    check(rv, 24'hFF);
    u_host.rd(7'h1B, rv);
    check(rv, 24'hFF);
    u_host.wr(7'h16, 16'h1234);
    u_host.rd(7'h16, rv);
    check(rv, 24'h0);
    results();
  end
endmodule
